// >>> ccw_exec.sv
// Execute stage for clear-accumulator, complement-file and watchdog-clear.
// Assumes file_rdata holds the register addressed by instr_word[6:0] in the
// cycle the word is valid, and that the register file performs the write
// that file_we_q requests one cycle later.
// Assumes wdt_tick and sleep_req are single-cycle strobes from the core; a level
// held high is taken again at every enabled edge.
// The core must not present a word whose operand is still being written back,
// as the write-back lands one edge after the word that requested it.
`timescale 1ns/1ns
`default_nettype none
`include "ccw_map.svh"

module ccw_exec
    import ccw_pkg::*;
#(
    parameter int DATA_W  = 8,
    parameter int PRESC_W = 8
)(
    input  wire logic              clk,
    input  wire logic              reset,
    input  wire logic              ce,
    input  wire logic              instr_valid,
    input  wire ccw_word_t         instr_word,
    input  wire logic [DATA_W-1:0] file_rdata,
    input  wire logic              wdt_tick,
    input  wire logic              sleep_req,
    output logic [DATA_W-1:0]      acc_q,
    output logic                   zero_flag_q,
    output logic                   timeout_status_bit_q,
    output logic                   powerdown_status_bit_q,
    output logic [DATA_W-1:0]      watchdog_counter_q,
    output logic [PRESC_W-1:0]     prescaler_q,
    output logic                   watchdog_overflow_q,
    output logic                   file_we_q,
    output ccw_faddr_t             file_waddr_q,
    output logic [DATA_W-1:0]      file_wdata_q,
    output logic                   done_q
);

    // --------------------------------------------------------------
    // Parameter checks
    // --------------------------------------------------------------

    // The accumulator and watchdog-clear reset constants are 8-bit wide.
    // A wider prescaler only lengthens the time-out; past 16 bits it is of no use.
    if (DATA_W != 8) begin : g_bad_data_w
        $error("DATA_W must be 8.");
    end
    if (PRESC_W < 1 || PRESC_W > 16) begin : g_bad_presc_w
        $error("PRESC_W must lie between 1 and 16.");
    end

    // --------------------------------------------------------------
    // Decode
    // --------------------------------------------------------------

    // The decoder only classifies the word; all state is kept in this module.
    ccw_dec_if dec_bus ();

    ccw_decode u_decode (
        .word_valid (instr_valid),
        .word       (instr_word),
        .dec        (dec_bus.dec)
    );

    // --------------------------------------------------------------
    // Watchdog and its status bits
    // --------------------------------------------------------------

    // Next values of the watchdog group.
    logic [DATA_W-1:0]  watchdog_counter_d;
    logic [PRESC_W-1:0] prescaler_d;
    logic               watchdog_overflow_d;
    logic               timeout_status_bit_d;
    logic               powerdown_status_bit_d;
    logic               watchdog_clear;

    // The clear is decoded once; the datapath group only flags its completion.
    assign watchdog_clear = (dec_bus.op == CCW_OP_WDT_CLEAR);

    // Next watchdog state. The clear is applied last, so it wins over a
    // tick, a counter wrap or a sleep request in the same cycle and
    // software never loses a clear to a racing time-out.
    always_comb begin
        watchdog_counter_d     = watchdog_counter_q;
        prescaler_d            = prescaler_q;
        watchdog_overflow_d    = 1'b0;
        timeout_status_bit_d   = timeout_status_bit_q;
        powerdown_status_bit_d = powerdown_status_bit_q;

        // The prescaler counts ticks and its wrap advances the counter.
        if (wdt_tick) begin
            prescaler_d = prescaler_q + PRESC_W'(1);
            if (&prescaler_q) begin
                watchdog_counter_d = watchdog_counter_q + DATA_W'(1);
                // A counter wrap reports a time-out by clearing the bit.
                if (&watchdog_counter_q) begin
                    watchdog_overflow_d  = 1'b1;
                    timeout_status_bit_d = 1'b0;
                end
            end
        end

        // Entering sleep clears the power-down bit.
        if (sleep_req) begin
            powerdown_status_bit_d = 1'b0;
        end

        if (watchdog_clear) begin
            watchdog_counter_d     = `CCW_WDT_CLEAR_VALUE;
            prescaler_d            = '0;
            watchdog_overflow_d    = 1'b0;
            timeout_status_bit_d   = 1'b1;
            powerdown_status_bit_d = 1'b1;
        end
    end

    // Watchdog registers only; the clock enable freezes them while low.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            watchdog_counter_q     <= `CCW_WDT_CLEAR_VALUE;
            prescaler_q            <= '0;
            watchdog_overflow_q    <= 1'b0;
            timeout_status_bit_q   <= `CCW_TIMEOUT_RESET;
            powerdown_status_bit_q <= `CCW_POWERDOWN_RESET;
        end else if (ce) begin
            watchdog_counter_q     <= watchdog_counter_d;
            prescaler_q            <= prescaler_d;
            watchdog_overflow_q    <= watchdog_overflow_d;
            timeout_status_bit_q   <= timeout_status_bit_d;
            powerdown_status_bit_q <= powerdown_status_bit_d;
        end
    end

    // --------------------------------------------------------------
    // Accumulator, zero flag and file write-back
    // --------------------------------------------------------------

    logic [DATA_W-1:0]  acc_d;
    logic               zero_flag_d;
    logic               file_we_d;
    ccw_faddr_t         file_waddr_d;
    logic [DATA_W-1:0]  file_wdata_d;
    logic               done_d;
    logic [DATA_W-1:0]  inverted;

    // The inversion feeds both destinations, so it is formed once. It is a
    // combinational path from the file read port into these registers.
    assign inverted = ~file_rdata;

    // Next datapath values; every handled operation completes in one cycle.
    // The write strobe is a one-cycle pulse, while address and data hold.
    always_comb begin
        acc_d        = acc_q;
        zero_flag_d  = zero_flag_q;
        file_we_d    = 1'b0;
        file_waddr_d = file_waddr_q;
        file_wdata_d = file_wdata_q;
        done_d       = 1'b0;

        case (dec_bus.op)
            CCW_OP_CLEAR_ACC: begin
                acc_d       = `CCW_ACC_RESET;
                zero_flag_d = 1'b1;
                done_d      = 1'b1;
            end
            CCW_OP_COMPLEMENT: begin
                // Address and data are registered with the strobe.
                if (dec_bus.dest_file) begin
                    file_we_d    = 1'b1;
                    file_waddr_d = dec_bus.faddr;
                    file_wdata_d = inverted;
                end else begin
                    acc_d = inverted;
                end
                zero_flag_d = (inverted == '0);
                done_d      = 1'b1;
            end
            CCW_OP_WDT_CLEAR: begin
                // The watchdog group does the work; only completion is flagged.
                done_d = 1'b1;
            end
            CCW_OP_NONE: begin
                // Unrelated words and idle cycles leave the datapath as it is.
                done_d = 1'b0;
            end
            default: begin
                done_d = 1'b0;
            end
        endcase
    end

    // Datapath registers only; the clock enable freezes them while low.
    // Write-back address and data start at zero so no stale value is seen.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            acc_q        <= `CCW_ACC_RESET;
            zero_flag_q  <= `CCW_ZERO_RESET;
            file_we_q    <= 1'b0;
            file_waddr_q <= '0;
            file_wdata_q <= '0;
            done_q       <= 1'b0;
        end else if (ce) begin
            acc_q        <= acc_d;
            zero_flag_q  <= zero_flag_d;
            file_we_q    <= file_we_d;
            file_waddr_q <= file_waddr_d;
            file_wdata_q <= file_wdata_d;
            done_q       <= done_d;
        end
    end

endmodule

`default_nettype wire

// >>> ccw_map.svh
// Constants for the clear, complement and watchdog-clear execute block.
// Assumes a 14-bit instruction word and an 8-bit data path.
`ifndef CCW_MAP_SVH
`define CCW_MAP_SVH

// ----------------------------------------------------------------------
// Instruction encodings
// ----------------------------------------------------------------------
`define CCW_INSTR_W          14
`define CCW_CLEAR_ACC_WORD   14'h0103
`define CCW_WDT_CLEAR_WORD   14'h0064
`define CCW_COMPLEMENT_OPC   6'h09

// ----------------------------------------------------------------------
// Field positions inside the instruction word
// ----------------------------------------------------------------------
`define CCW_OPC_MSB          13
`define CCW_OPC_LSB          8
`define CCW_DEST_BIT         7
`define CCW_FADDR_MSB        6
`define CCW_FADDR_LSB        0
`define CCW_FADDR_MAX        127

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define CCW_ACC_RESET        8'h00
`define CCW_ZERO_RESET       1'b0
`define CCW_TIMEOUT_RESET    1'b1
`define CCW_POWERDOWN_RESET  1'b1
`define CCW_WDT_CLEAR_VALUE  8'h00

// ----------------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------------
`define CCW_EXEC_CYCLES      1

`endif

// >>> ccw_pkg.sv
// Types shared by the execute block and its decoder.
// Assumes ccw_map.svh is on the include path.
`include "ccw_map.svh"

package ccw_pkg;

    // Which of the three handled operations is in the current word.
    typedef enum logic [1:0] {
        CCW_OP_NONE,
        CCW_OP_CLEAR_ACC,
        CCW_OP_COMPLEMENT,
        CCW_OP_WDT_CLEAR
    } ccw_op_e;

    typedef logic [`CCW_INSTR_W-1:0] ccw_word_t;
    typedef logic [`CCW_FADDR_MSB:0] ccw_faddr_t;

endpackage

// >>> ccw_dec_if.sv
// Carrier between the decoder and the execute stage.
// Assumes both ends run on the same core clock.
`timescale 1ns/1ns
`default_nettype none

interface ccw_dec_if;
    import ccw_pkg::*;

    ccw_op_e    op;
    logic       dest_file;
    ccw_faddr_t faddr;

    modport dec (output op, output dest_file, output faddr);
    modport exe (input op, input dest_file, input faddr);
endinterface

`default_nettype wire

// >>> ccw_decode.sv
// Combinational decoder for the three handled instruction words.
// Assumes the word is only looked at while it is marked valid.
`timescale 1ns/1ns
`default_nettype none
`include "ccw_map.svh"

module ccw_decode
    import ccw_pkg::*;
(
    input  wire logic      word_valid,
    input  wire ccw_word_t word,
    ccw_dec_if.dec         dec
);

    // --------------------------------------------------------------
    // Opcode match
    // --------------------------------------------------------------

    // Picks the operation; unrelated words decode to no operation.
    always_comb begin
        dec.op        = CCW_OP_NONE;
        dec.dest_file = word[`CCW_DEST_BIT];
        dec.faddr     = word[`CCW_FADDR_MSB:`CCW_FADDR_LSB];
        if (word_valid) begin
            if (word == `CCW_CLEAR_ACC_WORD) begin
                dec.op = CCW_OP_CLEAR_ACC;
            end else if (word == `CCW_WDT_CLEAR_WORD) begin
                dec.op = CCW_OP_WDT_CLEAR;
            end else if (word[`CCW_OPC_MSB:`CCW_OPC_LSB] == `CCW_COMPLEMENT_OPC) begin
                dec.op = CCW_OP_COMPLEMENT;
            end
        end
    end

endmodule

`default_nettype wire

// >>> ccw_exec_checker.sv
// Port assertions for the clear, complement and watchdog-clear stage.
// Assumes ccw_pkg is compiled first; bound to ccw_exec below.
`timescale 1ns/1ns
`default_nettype none
`include "ccw_map.svh"
module ccw_exec_checker
    import ccw_pkg::*;
#(
    parameter int DATA_W  = 8,
    parameter int PRESC_W = 8
)(
    input wire logic               clk,
    input wire logic               reset,
    input wire logic               ce,
    input wire logic               instr_valid,
    input wire ccw_word_t          instr_word,
    input wire logic [DATA_W-1:0]  file_rdata,
    input wire logic               wdt_tick,
    input wire logic               sleep_req,
    input wire logic [DATA_W-1:0]  acc_q,
    input wire logic               zero_flag_q,
    input wire logic               timeout_status_bit_q,
    input wire logic               powerdown_status_bit_q,
    input wire logic [DATA_W-1:0]  watchdog_counter_q,
    input wire logic [PRESC_W-1:0] prescaler_q,
    input wire logic               watchdog_overflow_q,
    input wire logic               file_we_q,
    input wire ccw_faddr_t         file_waddr_q,
    input wire logic [DATA_W-1:0]  file_wdata_q,
    input wire logic               done_q
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // Words taken at an enabled edge, one sequence per operation.
    sequence s_clr; ce && instr_valid && instr_word == `CCW_CLEAR_ACC_WORD; endsequence
    sequence s_wdt; ce && instr_valid && instr_word == `CCW_WDT_CLEAR_WORD; endsequence
    sequence s_comp; ce && instr_valid && instr_word[13:8] == `CCW_COMPLEMENT_OPC; endsequence
    // Each result must be visible one edge after the word is taken.
    a_clear_acc_zero: assert property (s_clr |=> acc_q == 0 && zero_flag_q && done_q)
        else $error("clear accumulator result wrong");
    a_comp_file_write: assert property (s_comp ##0 instr_word[7] |=> file_we_q
        && file_wdata_q == ~$past(file_rdata) && file_waddr_q == $past(instr_word[6:0]))
        else $error("complement write-back wrong");
    a_comp_acc_dest: assert property (s_comp ##0 !instr_word[7] |=>
        acc_q == ~$past(file_rdata) && !file_we_q)
        else $error("complement to accumulator wrong");
    a_comp_acc_keep: assert property (s_comp ##0 instr_word[7] |=> $stable(acc_q))
        else $error("accumulator changed by file write-back");
    a_wdt_clear_zero: assert property (s_wdt |=> watchdog_counter_q == 0 && prescaler_q == 0)
        else $error("watchdog clear left counts");
    a_wdt_status_set: assert property (s_wdt |=> timeout_status_bit_q && powerdown_status_bit_q)
        else $error("watchdog clear left status low");
    a_comp_zero_flag: assert property (s_comp |=> zero_flag_q == ($past(file_rdata) == 8'hff))
        else $error("complement zero flag wrong");
    a_comp_status_keep: assert property (s_comp ##0 !wdt_tick && !sleep_req |=>
        $stable(timeout_status_bit_q) && $stable(powerdown_status_bit_q))
        else $error("complement touched other status");
    a_overflow_timeout: assert property (watchdog_overflow_q |-> !timeout_status_bit_q)
        else $error("overflow without time-out status");
endmodule
bind ccw_exec ccw_exec_checker #(.DATA_W(DATA_W), .PRESC_W(PRESC_W)) chk_i (.clk, .reset, .ce,
    .instr_valid, .instr_word, .file_rdata, .wdt_tick, .sleep_req, .acc_q, .zero_flag_q,
    .timeout_status_bit_q, .powerdown_status_bit_q, .watchdog_counter_q, .prescaler_q,
    .watchdog_overflow_q, .file_we_q, .file_waddr_q, .file_wdata_q, .done_q);
`default_nettype wire

// >>> ccw_file_model.sv
// File register model on the far side of the execute stage.
// Assumes the write request comes one edge after the word is taken.
`timescale 1ns/1ns
`default_nettype none
module ccw_file_model
    import ccw_pkg::*;
(
    input  wire logic       clk,
    input  wire ccw_faddr_t raddr,
    input  wire logic       we,
    input  wire ccw_faddr_t waddr,
    input  wire logic [7:0] wdata,
    output logic [7:0]      rdata
);
    logic [7:0] mem [128];
    // Operand is read at once, covering addresses 0 to 127.
    assign rdata = mem[raddr];
    // Stores a write-back result.
    always @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end
endmodule
`default_nettype wire

// >>> ccw_exec_tb.sv
// Self-checking bench for the execute stage.
// Assumes the design files and the file register model are compiled first.
`timescale 1ns/1ns
`default_nettype none
module ccw_exec_tb;
    import ccw_pkg::*;
    logic       clk = 1'b0, reset = 1'b1, ce = 1'b1, instr_valid = 1'b0;
    logic       wdt_tick = 1'b0, sleep_req = 1'b0;
    ccw_word_t  instr_word = '0;
    logic [7:0] rdata, acc, cnt, wdata;
    logic [0:0] presc;
    logic       zf, to_b, pwrdn_b, we, done, ovf;
    ccw_faddr_t waddr;
    int         fails = 0;
    int         total_checks = 0;
    int         n_ovf = 0;
    ccw_exec #(.PRESC_W(1)) ccw_exec_i (.clk(clk), .reset(reset), .ce(ce),
        .instr_valid(instr_valid), .instr_word(instr_word), .file_rdata(rdata),
        .wdt_tick(wdt_tick), .sleep_req(sleep_req), .acc_q(acc), .zero_flag_q(zf),
        .timeout_status_bit_q(to_b), .powerdown_status_bit_q(pwrdn_b), .watchdog_counter_q(cnt),
        .prescaler_q(presc), .watchdog_overflow_q(ovf), .file_we_q(we), .file_waddr_q(waddr),
        .file_wdata_q(wdata), .done_q(done));
    ccw_file_model ccw_file_model_i (.clk(clk), .raddr(instr_word[6:0]), .we(we),
        .waddr(waddr), .wdata(wdata), .rdata(rdata));
    // Free-running 100 MHz clock.
    always #5 clk = ~clk;
    task check(string what, logic [15:0] seen, logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task step(logic v, ccw_word_t w);
        instr_valid = v;
        instr_word = w;
        @(posedge clk);
        #1;
    endtask
    task report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task t_clear_acc();
        ccw_file_model_i.mem[5] = 8'ha5;
        step(1'b1, 14'h0905);
        check("acc", acc, 16'h005a);
        check("zero", zf, 16'h0000);
        step(1'b1, 14'h0103);
        check("acc", acc, 16'h0000);
        check("zero", zf, 16'h0001);
        step(1'b0, 14'h0000);
        $display("clear test over");
    endtask
    task t_comp_file();
        ccw_file_model_i.mem[127] = 8'h13;
        ccw_file_model_i.mem[0] = 8'hff;
        step(1'b1, 14'h09ff);
        check("wdata", wdata, 16'h00ec);
        check("waddr", waddr, 16'h007f);
        check("acc", acc, 16'h0000);
        step(1'b1, 14'h0980);
        check("zero", zf, 16'h0001);
        check("status", {to_b, pwrdn_b}, 16'h0003);
        step(1'b1, 14'h0104);
        check("done", done, 16'h0000);
        check("mem", ccw_file_model_i.mem[127], 16'h00ec);
        ce = 1'b0;
        step(1'b1, 14'h0103);
        check("frozen", {acc, done}, 16'h0000);
        ce = 1'b1;
        $display("complement test over");
    endtask
    task t_wdt();
        wdt_tick = 1'b1;
        step(1'b0, 14'h0000);
        // The 512th tick wraps the counter, so exactly one pulse is seen.
        repeat (520) begin
            @(posedge clk);
            #1;
            if (ovf === 1'b1) begin
                n_ovf++;
            end
        end
        check("overflows", n_ovf[15:0], 16'h0001);
        check("timeout", to_b, 16'h0000);
        sleep_req = 1'b1;
        step(1'b0, 14'h0000);
        sleep_req = 1'b0;
        check("powerdown", pwrdn_b, 16'h0000);
        step(1'b1, 14'h0064);
        check("counts", {cnt, 7'h00, presc}, 16'h0000);
        check("status", {to_b, pwrdn_b, done}, 16'h0007);
        wdt_tick = 1'b0;
        $display("watchdog test over");
    endtask
    // Main sequence after an eight-cycle reset.
    initial begin
        repeat (8) @(posedge clk);
        #1;
        reset = 1'b0;
        check("reset", {acc, zf, to_b, pwrdn_b, done, we}, 16'h000c);
        t_clear_acc();
        t_comp_file();
        t_wdt();
        report_and_stop();
    end
    // Cuts a hang short well beyond the expected run.
    initial begin
        #50000;
        fails++;
        report_and_stop();
    end
endmodule
`default_nettype wire
